// [core/cmr_config_regs.sv]
module cmr_config_regs
    import cmr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Serial control port pins
    input wire logic ctrl_sen_n,
    input wire logic ctrl_sclk,
    input wire logic ctrl_sdi,
    output logic ctrl_sdo,
    output logic ctrl_sdo_oe,
    // Speed grade strap, high on the fastest grade
    input wire logic grade_fast_strap,
    // Sampling and auto-zero controls
    output logic sampling_loop_powerdown,
    output logic sampling_window_quarter,
    output logic autozero_active,
    // Bit mapping
    output logic [7:0] bit_map_select,
    output logic bit_map_loaded,
    // Test pattern
    output logic [17:0] fixed_pattern_value,
    output cmr_pkg::cmr_source_type chan_b_source
);
    import cmr_pkg::*;

    typedef struct packed {
        logic [7:0] iface_select;
        logic [7:0] sampling_loop_autozero_ctrl;
        logic [7:0] bit_map_load_ctrl;
        logic [7:0] pattern_value_low;
        logic [7:0] pattern_value_mid;
        logic [7:0] pattern_select_and_value_high;
        logic grade_taken;
        logic grade_fast;
        logic [1:0] grade_wait;
        logic loop_pdn;
        logic window_quarter;
        logic autozero_on;
        logic [7:0] bit_map;
        logic map_loaded;
        logic [17:0] pattern;
        cmr_source_type source;
    } cmr_regs_state_type;

    cmr_regs_state_type state;
    cmr_regs_state_type next_state;

    logic [3:0] pins_sync;
    logic wr_strobe;
    logic [14:0] wr_addr;
    logic [7:0] wr_data;
    logic [14:0] rd_addr;
    logic [7:0] rd_data;

    function automatic logic [7:0] reg_read(input cmr_regs_state_type s,
                                            input logic [14:0] addr);
        logic [7:0] value;
        value = 8'h00;
        case (addr)
            ADDR_IFACE_SELECT: value = s.iface_select;
            ADDR_SAMPLING_LOOP_AUTOZERO_CTRL: value = s.sampling_loop_autozero_ctrl;
            ADDR_BIT_MAP_LOAD_CTRL: value = s.bit_map_load_ctrl;
            ADDR_PATTERN_VALUE_LOW: value = s.pattern_value_low;
            ADDR_PATTERN_VALUE_MID: value = s.pattern_value_mid;
            ADDR_PATTERN_SELECT_AND_VALUE_HIGH: value = s.pattern_select_and_value_high;
            default: value = 8'h00;
        endcase
        return value;
    endfunction

    // Decodes the channel B selector; unused codes fall back to normal data
    function automatic cmr_source_type decode_source(input logic [2:0] code);
        cmr_source_type src;
        src = CMR_SRC_NORMAL;
        case (code)
            SEL_CODE_RAMP: src = CMR_SRC_RAMP;
            SEL_CODE_CONSTANT: src = CMR_SRC_CONSTANT;
            default: src = CMR_SRC_NORMAL;
        endcase
        return src;
    endfunction

    cmr_sync u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({grade_fast_strap, ctrl_sdi, ctrl_sclk, ctrl_sen_n}),
        .sync_out(pins_sync)
    );

    cmr_serial_port u_port (
        .sys_clk(sys_clk),
        .reset(reset),
        .sen_n(pins_sync[0]),
        .sclk(pins_sync[1]),
        .sdi(pins_sync[2]),
        .wr_strobe(wr_strobe),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .sdo(ctrl_sdo),
        .sdo_oe(ctrl_sdo_oe)
    );

    assign rd_data = reg_read(state, rd_addr);

    always_comb begin
        logic pdn_bit;
        logic az_bit;
        pdn_bit = 1'b0;
        az_bit = 1'b0;
        next_state = state;
        next_state.map_loaded = 1'b0;

        // Grade strap caught once, after the synchroniser has refilled from reset
        if (!state.grade_taken) begin
            if (state.grade_wait == 2'(GRADE_SETTLE_CYCLES)) begin
                next_state.grade_taken = 1'b1;
                next_state.grade_fast = pins_sync[3];
            end else begin
                next_state.grade_wait = state.grade_wait + 2'h1;
            end
        end

        if (wr_strobe) begin
            // All bits are stored as written; unassigned ones drive nothing
            case (wr_addr)
                ADDR_IFACE_SELECT: next_state.iface_select = wr_data;
                ADDR_SAMPLING_LOOP_AUTOZERO_CTRL: begin
                    next_state.sampling_loop_autozero_ctrl = wr_data;
                end
                ADDR_BIT_MAP_LOAD_CTRL: begin
                    next_state.bit_map_load_ctrl = wr_data;
                    // Mapping loads when the trigger returns from one to zero
                    if (state.bit_map_load_ctrl[BIT_MAP_LOAD_TRIGGER_BIT]
                        && !wr_data[BIT_MAP_LOAD_TRIGGER_BIT]) begin
                        next_state.bit_map = state.iface_select;
                        next_state.map_loaded = 1'b1;
                        // Load wipes earlier settings except 0x07 and 0x13
                        next_state.sampling_loop_autozero_ctrl =
                            RST_SAMPLING_LOOP_AUTOZERO_CTRL;
                        next_state.pattern_value_low = RST_PATTERN_VALUE_LOW;
                        next_state.pattern_value_mid = RST_PATTERN_VALUE_MID;
                        next_state.pattern_select_and_value_high =
                            RST_PATTERN_SELECT_AND_VALUE_HIGH;
                    end
                end
                ADDR_PATTERN_VALUE_LOW: next_state.pattern_value_low = wr_data;
                ADDR_PATTERN_VALUE_MID: next_state.pattern_value_mid = wr_data;
                ADDR_PATTERN_SELECT_AND_VALUE_HIGH: begin
                    next_state.pattern_select_and_value_high = wr_data;
                end
                default: next_state.iface_select = state.iface_select;
            endcase
        end

        pdn_bit = state.sampling_loop_autozero_ctrl[SAMPLING_LOOP_POWERDOWN_BIT];
        az_bit = state.sampling_loop_autozero_ctrl[AUTOZERO_CONTROL_BIT];

        // Loop can be powered down only on the fastest grade
        next_state.loop_pdn = state.grade_fast && pdn_bit;
        next_state.window_quarter = !(state.grade_fast && pdn_bit);
        // Auto-zero polarity depends on grade
        if (state.grade_fast) begin
            next_state.autozero_on = az_bit;
        end else begin
            next_state.autozero_on = !az_bit;
        end

        // Constant word or ramp step, MSB in the high register
        next_state.pattern = {
            state.pattern_select_and_value_high[PATTERN_VALUE_HIGH_MSB:0],
            state.pattern_value_mid,
            state.pattern_value_low
        };
        next_state.source = decode_source(
            state.pattern_select_and_value_high[CHAN_B_PATTERN_SELECT_MSB:
                                                CHAN_B_PATTERN_SELECT_LSB]);
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
            state.iface_select <= RST_IFACE_SELECT;
            state.sampling_loop_autozero_ctrl <= RST_SAMPLING_LOOP_AUTOZERO_CTRL;
            state.bit_map_load_ctrl <= RST_BIT_MAP_LOAD_CTRL;
            state.pattern_value_low <= RST_PATTERN_VALUE_LOW;
            state.pattern_value_mid <= RST_PATTERN_VALUE_MID;
            state.pattern_select_and_value_high <= RST_PATTERN_SELECT_AND_VALUE_HIGH;
            state.window_quarter <= 1'b1;
            state.source <= CMR_SRC_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    assign sampling_loop_powerdown = state.loop_pdn;
    assign sampling_window_quarter = state.window_quarter;
    assign autozero_active = state.autozero_on;
    assign bit_map_select = state.bit_map;
    assign bit_map_loaded = state.map_loaded;
    assign fixed_pattern_value = state.pattern;
    assign chan_b_source = state.source;

endmodule

// [core/cmr_pkg.sv]
package cmr_pkg;

    // Serial frame: read/write flag, 15 address bits, 8 data bits, MSB first
    localparam int FRAME_BITS = 24;
    localparam int HEADER_BITS = 16;
    localparam int ADDR_W = 15;

    // Cycles for the strap synchroniser to refill after reset release
    localparam int GRADE_SETTLE_CYCLES = 2;

    // Register offsets
    localparam logic [14:0] ADDR_IFACE_SELECT = 15'h0007;
    localparam logic [14:0] ADDR_SAMPLING_LOOP_AUTOZERO_CTRL = 15'h0011;
    localparam logic [14:0] ADDR_BIT_MAP_LOAD_CTRL = 15'h0013;
    localparam logic [14:0] ADDR_PATTERN_VALUE_LOW = 15'h0014;
    localparam logic [14:0] ADDR_PATTERN_VALUE_MID = 15'h0015;
    localparam logic [14:0] ADDR_PATTERN_SELECT_AND_VALUE_HIGH = 15'h0016;

    // Reset values
    localparam logic [7:0] RST_IFACE_SELECT = 8'h00;
    localparam logic [7:0] RST_SAMPLING_LOOP_AUTOZERO_CTRL = 8'h00;
    localparam logic [7:0] RST_BIT_MAP_LOAD_CTRL = 8'h00;
    localparam logic [7:0] RST_PATTERN_VALUE_LOW = 8'h00;
    localparam logic [7:0] RST_PATTERN_VALUE_MID = 8'h00;
    localparam logic [7:0] RST_PATTERN_SELECT_AND_VALUE_HIGH = 8'h00;

    // Field positions
    localparam int SAMPLING_LOOP_POWERDOWN_BIT = 2;
    localparam int AUTOZERO_CONTROL_BIT = 0;
    localparam int BIT_MAP_LOAD_TRIGGER_BIT = 0;
    localparam int CHAN_B_PATTERN_SELECT_MSB = 7;
    localparam int CHAN_B_PATTERN_SELECT_LSB = 5;
    localparam int PATTERN_VALUE_HIGH_MSB = 1;

    // Channel B selector codes
    localparam logic [2:0] SEL_CODE_NORMAL = 3'h0;
    localparam logic [2:0] SEL_CODE_RAMP = 3'h2;
    localparam logic [2:0] SEL_CODE_CONSTANT = 3'h3;

    typedef enum logic [1:0] {
        CMR_SRC_NORMAL,
        CMR_SRC_RAMP,
        CMR_SRC_CONSTANT
    } cmr_source_type;

endpackage

// [core/cmr_serial_port.sv]
module cmr_serial_port
    import cmr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Synchronised pins
    input wire logic sen_n,
    input wire logic sclk,
    input wire logic sdi,
    // Register access
    output logic wr_strobe,
    output logic [14:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [14:0] rd_addr,
    input wire logic [7:0] rd_data,
    // Serial data out
    output logic sdo,
    output logic sdo_oe
);

    typedef struct packed {
        logic sclk_d;
        logic [4:0] bit_cnt;
        logic [23:0] shift;
        logic rw;
        logic [14:0] addr;
        logic load_pend;
        logic [7:0] out_sh;
        logic sdo;
        logic sdo_oe;
        logic wr_strobe;
        logic [14:0] wr_addr;
        logic [7:0] wr_data;
    } cmr_port_state_type;

    cmr_port_state_type state;
    cmr_port_state_type next_state;

    always_comb begin
        next_state = state;
        next_state.wr_strobe = 1'b0;
        next_state.sclk_d = sclk;
        if (sen_n) begin
            next_state.bit_cnt = 5'h00;
            next_state.load_pend = 1'b0;
            next_state.sdo_oe = 1'b0;
            next_state.sdo = 1'b0;
        end else begin
            if (state.load_pend) begin
                next_state.load_pend = 1'b0;
                next_state.out_sh = rd_data;
                next_state.sdo = rd_data[7];
                next_state.sdo_oe = 1'b1;
            end
            if (sclk && !state.sclk_d && state.bit_cnt < 5'(FRAME_BITS)) begin
                next_state.shift = {state.shift[22:0], sdi};
                next_state.bit_cnt = state.bit_cnt + 5'h01;
                if (state.bit_cnt == 5'(HEADER_BITS - 1)) begin
                    next_state.rw = state.shift[14];
                    next_state.addr = {state.shift[13:0], sdi};
                    next_state.load_pend = state.shift[14];
                end
                if (state.bit_cnt == 5'(FRAME_BITS - 1) && !state.rw) begin
                    next_state.wr_strobe = 1'b1;
                    next_state.wr_addr = state.addr;
                    next_state.wr_data = {state.shift[6:0], sdi};
                end
            end
            if (!sclk && state.sclk_d && state.sdo_oe) begin
                next_state.out_sh = {state.out_sh[6:0], 1'b0};
                next_state.sdo = state.out_sh[6];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign wr_strobe = state.wr_strobe;
    assign wr_addr = state.wr_addr;
    assign wr_data = state.wr_data;
    assign rd_addr = state.addr;
    assign sdo = state.sdo;
    assign sdo_oe = state.sdo_oe;

endmodule

// [core/cmr_sync.sv]
module cmr_sync (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Raw pin levels
    input wire logic [3:0] async_in,
    // Levels on sys_clk
    output logic [3:0] sync_out
);

    typedef struct packed {
        logic [3:0] stage1;
        logic [3:0] stage2;
    } cmr_sync_state_type;

    cmr_sync_state_type state;
    cmr_sync_state_type next_state;

    always_comb begin
        next_state.stage1 = async_in;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stage2;

endmodule

// [tb/cmr_config_regs_bench.sv]
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end

module cmr_config_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import cmr_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic ctrl_sen_n = 1'b1;
    logic ctrl_sclk = 1'b0;
    logic ctrl_sdi = 1'b0;
    logic grade_fast_strap = 1'b0;
    logic ctrl_sdo, ctrl_sdo_oe, sampling_loop_powerdown, sampling_window_quarter;
    logic autozero_active, bit_map_loaded;
    logic [7:0] bit_map_select;
    logic [17:0] fixed_pattern_value;
    cmr_source_type chan_b_source;
    int mismatches = 0;
    int cmp_count = 0;
    int load_pulses = 0;
    logic [7:0] rd;

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (bit_map_loaded === 1'b1) load_pulses++;

    cmr_config_regs cmr_config_regs_inst (
        .sys_clk(sys_clk), .reset(reset),
        .ctrl_sen_n(ctrl_sen_n), .ctrl_sclk(ctrl_sclk), .ctrl_sdi(ctrl_sdi),
        .ctrl_sdo(ctrl_sdo), .ctrl_sdo_oe(ctrl_sdo_oe), .grade_fast_strap(grade_fast_strap),
        .sampling_loop_powerdown(sampling_loop_powerdown),
        .sampling_window_quarter(sampling_window_quarter), .autozero_active(autozero_active),
        .bit_map_select(bit_map_select), .bit_map_loaded(bit_map_loaded),
        .fixed_pattern_value(fixed_pattern_value), .chan_b_source(chan_b_source)
    );

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Strap settles during the six reset cycles, well before release
    task automatic do_reset(input logic fast);
        @(negedge sys_clk);
        reset = 1'b1;
        grade_fast_strap = fast;
        cyc(6);
        reset = 1'b0;
        cyc(5);
    endtask

    // One frame, five cycles per sclk phase; read bit n sampled late in high phase n+1
    task automatic xfer(input logic rw, input logic [14:0] addr, input logic [7:0] data);
        logic [23:0] frame;
        frame = {rw, addr, data};
        rd = 8'h00;
        ctrl_sen_n = 1'b0;
        cyc(5);
        for (int i = 23; i >= 0; i--) begin
            ctrl_sclk = 1'b0;
            ctrl_sdi = frame[i];
            cyc(5);
            ctrl_sclk = 1'b1;
            cyc(5);
            if (i >= 1 && i <= 8) rd[i - 1] = ctrl_sdo;
        end
        ctrl_sclk = 1'b0;
        cyc(5);
        ctrl_sen_n = 1'b1;
        ctrl_sdi = 1'b0;
        cyc(5);
    endtask

    task automatic wr(input logic [14:0] addr, input logic [7:0] data);
        xfer(1'b0, addr, data);
    endtask

    task automatic rdchk(input logic [14:0] addr, input logic [7:0] exp);
        xfer(1'b1, addr, 8'h00);
        `CHK(rd, exp)
    endtask

    task automatic t_reset_values;
        do_reset(1'b0);
        `CHK(sampling_window_quarter, 1'b1)
        `CHK(autozero_active, 1'b1)
        `CHK(chan_b_source, CMR_SRC_NORMAL)
        rdchk(ADDR_SAMPLING_LOOP_AUTOZERO_CTRL, RST_SAMPLING_LOOP_AUTOZERO_CTRL);
        rdchk(ADDR_BIT_MAP_LOAD_CTRL, RST_BIT_MAP_LOAD_CTRL);
        rdchk(ADDR_PATTERN_VALUE_LOW, RST_PATTERN_VALUE_LOW);
        rdchk(ADDR_PATTERN_VALUE_MID, RST_PATTERN_VALUE_MID);
        rdchk(ADDR_PATTERN_SELECT_AND_VALUE_HIGH, RST_PATTERN_SELECT_AND_VALUE_HIGH);
    endtask

    task automatic t_slow_grade;
        wr(ADDR_SAMPLING_LOOP_AUTOZERO_CTRL, 8'h05);
        `CHK(sampling_loop_powerdown, 1'b0)
        `CHK(sampling_window_quarter, 1'b1)
        `CHK(autozero_active, 1'b0)
        rdchk(ADDR_SAMPLING_LOOP_AUTOZERO_CTRL, 8'h05);
        wr(ADDR_SAMPLING_LOOP_AUTOZERO_CTRL, 8'h00);
        `CHK(autozero_active, 1'b1)
    endtask

    task automatic t_fast_grade;
        do_reset(1'b1);
        `CHK(autozero_active, 1'b0)
        wr(ADDR_SAMPLING_LOOP_AUTOZERO_CTRL, 8'h04);
        `CHK(sampling_loop_powerdown, 1'b1)
        `CHK(sampling_window_quarter, 1'b0)
        `CHK(autozero_active, 1'b0)
        wr(ADDR_SAMPLING_LOOP_AUTOZERO_CTRL, 8'h01);
        `CHK(sampling_loop_powerdown, 1'b0)
        `CHK(sampling_window_quarter, 1'b1)
        `CHK(autozero_active, 1'b1)
    endtask

    task automatic t_pattern;
        cmr_source_type exp;
        wr(ADDR_PATTERN_VALUE_LOW, 8'hA5);
        wr(ADDR_PATTERN_VALUE_MID, 8'h3C);
        wr(ADDR_PATTERN_SELECT_AND_VALUE_HIGH, 8'h62);
        `CHK(fixed_pattern_value, 18'h2_3CA5)
        `CHK(chan_b_source, CMR_SRC_CONSTANT)
        for (int code = 0; code < 8; code++) begin
            wr(ADDR_PATTERN_SELECT_AND_VALUE_HIGH, {code[2:0], 5'h00});
            exp = (code == 2) ? CMR_SRC_RAMP : (code == 3) ? CMR_SRC_CONSTANT : CMR_SRC_NORMAL;
            `CHK(chan_b_source, exp)
        end
        wr(ADDR_PATTERN_VALUE_LOW, 8'h01);
        wr(ADDR_PATTERN_VALUE_MID, 8'h00);
        wr(ADDR_PATTERN_SELECT_AND_VALUE_HIGH, 8'h40);
        `CHK(fixed_pattern_value, 18'h0_0001)
        `CHK(chan_b_source, CMR_SRC_RAMP)
    endtask

    task automatic t_unmapped;
        wr(15'h0012, 8'hFF);
        rdchk(15'h0012, 8'h00);
    endtask

    task automatic t_load;
        int base;
        wr(ADDR_IFACE_SELECT, 8'h5A);
        wr(ADDR_SAMPLING_LOOP_AUTOZERO_CTRL, 8'h01);
        wr(ADDR_PATTERN_VALUE_LOW, 8'h77);
        base = load_pulses;
        wr(ADDR_BIT_MAP_LOAD_CTRL, 8'h01);
        `CHK(load_pulses, base)
        `CHK(bit_map_select, 8'h00)
        wr(ADDR_BIT_MAP_LOAD_CTRL, 8'h00);
        `CHK(load_pulses, base + 1)
        `CHK(bit_map_select, 8'h5A)
        rdchk(ADDR_SAMPLING_LOOP_AUTOZERO_CTRL, 8'h00);
        rdchk(ADDR_PATTERN_VALUE_LOW, 8'h00);
        rdchk(ADDR_IFACE_SELECT, 8'h5A);
        rdchk(ADDR_BIT_MAP_LOAD_CTRL, 8'h00);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Hang guard: far above the length of the whole sequence
    initial begin
        repeat (60000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end

    initial begin
        t_reset_values();
        t_slow_grade();
        t_pattern();
        t_unmapped();
        t_fast_grade();
        t_load();
        wrap_up();
    end
endmodule

// [tb/cmr_config_regs_properties.sv]
module cmr_config_regs_props
    import cmr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Serial control port
    input wire logic ctrl_sen_n,
    input wire logic ctrl_sdo,
    input wire logic ctrl_sdo_oe,
    // Grade and controls
    input wire logic grade_fast_strap,
    input wire logic sampling_loop_powerdown,
    input wire logic sampling_window_quarter,
    // Mapping and pattern
    input wire logic [7:0] bit_map_select,
    input wire logic bit_map_loaded,
    input wire logic [17:0] fixed_pattern_value,
    input wire cmr_pkg::cmr_source_type chan_b_source
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Port deselected long enough for any pending write to have landed
    sequence port_idle;
        ctrl_sen_n [*4];
    endsequence

    a_window_follows_loop: assert property (sampling_window_quarter == !sampling_loop_powerdown)
        else $error("sampling window does not follow loop state");
    a_powerdown_fast_only: assert property (sampling_loop_powerdown |-> grade_fast_strap)
        else $error("loop powered down on a slow grade");
    a_load_single_pulse: assert property (bit_map_loaded |=> !bit_map_loaded)
        else $error("load pulse longer than one cycle");
    a_select_on_load: assert property ($changed(bit_map_select) |->
        (bit_map_loaded || $past(bit_map_loaded)))
        else $error("bit map changed without a load");
    a_load_in_frame: assert property (bit_map_loaded |-> !ctrl_sen_n)
        else $error("load completed outside a frame");
    a_pattern_idle_stable: assert property (port_idle |->
        $stable(fixed_pattern_value) && $stable(chan_b_source))
        else $error("pattern outputs moved while port idle");
    a_sdo_idle_off: assert property (port_idle |-> !ctrl_sdo_oe && !ctrl_sdo)
        else $error("serial output driven while port idle");
    a_sdo_oe_framed: assert property ($rose(ctrl_sdo_oe) |-> !ctrl_sen_n)
        else $error("serial output enabled outside a frame");
    a_source_code_legal: assert property (chan_b_source inside
        {CMR_SRC_NORMAL, CMR_SRC_RAMP, CMR_SRC_CONSTANT})
        else $error("channel B source out of range");
endmodule

bind cmr_config_regs cmr_config_regs_props cmr_config_regs_props_inst (
    .sys_clk(sys_clk),
    .reset(reset),
    .ctrl_sen_n(ctrl_sen_n),
    .ctrl_sdo(ctrl_sdo),
    .ctrl_sdo_oe(ctrl_sdo_oe),
    .grade_fast_strap(grade_fast_strap),
    .sampling_loop_powerdown(sampling_loop_powerdown),
    .sampling_window_quarter(sampling_window_quarter),
    .bit_map_select(bit_map_select),
    .bit_map_loaded(bit_map_loaded),
    .fixed_pattern_value(fixed_pattern_value),
    .chan_b_source(chan_b_source)
);
